// ### src/sgp_pkg.sv
// shared constants of the pin / pwm / limit configuration register set
package sgp_pkg;
	localparam int CLK_HZ = 100_000_000;
	localparam int CLK_MHZ = CLK_HZ / 1_000_000;
	// register addresses (7-bit command address)
	localparam logic [6:0] ADDR_PIN_FUNC = 7'h17;
	localparam logic [6:0] ADDR_DUTY = 7'h18;
	localparam logic [6:0] ADDR_RATE = 7'h1C;
	localparam logic [6:0] ADDR_THERM = 7'h1D;
	localparam logic [6:0] ADDR_RET_LO = 7'h1E;
	localparam logic [6:0] ADDR_RET_HI = 7'h1F;
	// field positions
	localparam int FUNC_MSB = 2;
	localparam int RATE_MSB = 1;
	localparam int THR_BIT = 2;
	localparam int LIM_MSB = 1;
	// power-on values
	localparam logic [2:0] FUNC_POR = 3'h0;
	localparam logic [7:0] DUTY_POR = 8'h00;
	localparam logic [1:0] RATE_POR = 2'h0;
	localparam logic [2:0] THERM_POR = 3'h1;
	localparam logic [7:0] RET_POR = 8'h00;
	// pin function codes
	localparam logic [2:0] FUNC_FAIL_MAX = 3'h2;
	localparam logic [2:0] FUNC_CYCLIC = 3'h3;
	localparam logic [2:0] FUNC_OFF = 3'h4;
	localparam logic [2:0] FUNC_WAKE = 3'h5;
	localparam logic [2:0] FUNC_PWM_LS = 3'h6;
	localparam logic [2:0] FUNC_PWM_HS = 3'h7;
	// pwm
	localparam logic [7:0] DUTY_FULL = 8'hFF;
	localparam logic [7:0] DUTY_OFF = 8'h00;
	localparam logic [7:0] SLOT_LAST = 8'hFE;
	localparam int SLOTS = 255;
	localparam int RATE_HZ_0 = 100;
	localparam int RATE_HZ_1 = 200;
	localparam int RATE_HZ_2 = 325;
	localparam int RATE_HZ_3 = 400;
	// wake input static filter, least time so rounded up
	localparam int WAKE_FILTER_NS = 16000;
	localparam int WAKE_FILTER_CYC = (WAKE_FILTER_NS * CLK_MHZ + 999) / 1000;
	// serial command
	localparam logic [4:0] CMD_BITS = 5'h10;
	localparam logic [4:0] ADDR_DONE = 5'h08;

	// clock cycles per pwm slot, a longest time so rounded down
	function automatic logic [11:0] slot_cycles(input logic [1:0] rate);
		int hz;
		case (rate)
			2'h0: hz = RATE_HZ_0;
			2'h1: hz = RATE_HZ_1;
			2'h2: hz = RATE_HZ_2;
			default: hz = RATE_HZ_3;
		endcase
		return 12'(CLK_HZ / (hz * SLOTS));
	endfunction
endpackage

// ### src/sgp_spi_port.sv
// serial command port: samples the link pins and frames 16-bit commands
`timescale 1ns/1ns
module sgp_spi_port (
	input wire logic clock, // system clock
	input wire logic rst, // synchronous reset, active high
	input wire logic chip_select_n, // link select, active low
	input wire logic spi_clk, // link clock
	input wire logic spi_mosi, // command data in
	input wire logic [7:0] rd_data, // read value of rd_addr
	output logic [6:0] rd_addr, // address of current command
	output logic wr_pulse, // one-cycle write commit
	output logic [6:0] wr_addr, // write address
	output logic [7:0] wr_data, // write data
	output logic cs_rise, // one-cycle pulse at end of frame
	output logic spi_miso, // reply data
	output logic spi_miso_oe // reply drive enable
);
	logic [2:0] sclk_sy_ff, cs_sy_ff;
	logic [1:0] mosi_sy_ff;
	logic [15:0] rx_ff;
	logic [4:0] cnt_ff;
	logic [6:0] addr_ff;
	logic [7:0] wdat_ff, tx_ff;
	logic wr_ff, cs_rise_ff, miso_ff, oe_ff;
	logic [6:0] waddr_ff;
	logic sclk_rise, sclk_fall, cs_active;

	always_ff @(posedge clock) begin
		if (rst) begin
			sclk_sy_ff <= 3'h0;
			cs_sy_ff <= 3'h7;
			mosi_sy_ff <= 2'h0;
		end else begin
			sclk_sy_ff <= {sclk_sy_ff[1:0], spi_clk};
			cs_sy_ff <= {cs_sy_ff[1:0], chip_select_n};
			mosi_sy_ff <= {mosi_sy_ff[0], spi_mosi};
		end
	end

	// edges are taken between second and third stage only
	assign sclk_rise = sclk_sy_ff[1] & ~sclk_sy_ff[2];
	assign sclk_fall = ~sclk_sy_ff[1] & sclk_sy_ff[2];
	assign cs_active = ~cs_sy_ff[1];

	// lsb first: address bits 0..6, access bit 7, then data byte
	always_ff @(posedge clock) begin
		if (rst || !cs_active) begin
			rx_ff <= 16'h0000;
			cnt_ff <= 5'h00;
		end else if (sclk_rise && cnt_ff != 5'h1F) begin
			rx_ff <= {mosi_sy_ff[1], rx_ff[15:1]};
			cnt_ff <= cnt_ff + 5'h01;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			addr_ff <= 7'h00;
		end else if (cs_active && cnt_ff == sgp_pkg::ADDR_DONE) begin
			addr_ff <= rx_ff[14:8];
		end
	end

	// reply: zero byte first, then the addressed register
	always_ff @(posedge clock) begin
		if (rst || !cs_active) begin
			tx_ff <= 8'h00;
			miso_ff <= 1'b0;
		end else if (sclk_fall && cnt_ff == sgp_pkg::ADDR_DONE) begin
			tx_ff <= {1'b0, rd_data[7:1]};
			miso_ff <= rd_data[0];
		end else if (sclk_fall && cnt_ff > sgp_pkg::ADDR_DONE) begin
			tx_ff <= {1'b0, tx_ff[7:1]};
			miso_ff <= tx_ff[0];
		end
	end

	// writes commit at the select rise, only for an exact 16-bit frame
	always_ff @(posedge clock) begin
		if (rst) begin
			wr_ff <= 1'b0;
			cs_rise_ff <= 1'b0;
			waddr_ff <= 7'h00;
			wdat_ff <= 8'h00;
			oe_ff <= 1'b0;
		end else begin
			cs_rise_ff <= cs_sy_ff[1] & ~cs_sy_ff[2];
			wr_ff <= cs_sy_ff[1] & ~cs_sy_ff[2]
				& (cnt_ff == sgp_pkg::CMD_BITS) & rx_ff[7];
			waddr_ff <= rx_ff[6:0];
			wdat_ff <= rx_ff[15:8];
			oe_ff <= cs_active;
		end
	end

	assign rd_addr = addr_ff;
	assign wr_pulse = wr_ff;
	assign wr_addr = waddr_ff;
	assign wr_data = wdat_ff;
	assign cs_rise = cs_rise_ff;
	assign spi_miso = miso_ff;
	assign spi_miso_oe = oe_ff;

	default clocking @(posedge clock); endclocking
	default disable iff (rst);

	chk_frame_len_write: assert property (wr_ff |-> $past(cnt_ff) ==
		sgp_pkg::CMD_BITS) else $error("write from a short frame");
endmodule // sgp_spi_port

// ### src/sgp_pwm_gen.sv
// pwm generator: 255 slots a period, settings taken at period end
`timescale 1ns/1ns
module sgp_pwm_gen (
	input wire logic clock, // system clock
	input wire logic rst, // synchronous reset, active high
	input wire logic [7:0] duty_value, // written duty
	input wire logic [1:0] rate_code, // written rate
	output logic pwm_on // switch on request
);
	logic [7:0] duty_act_ff;
	logic [1:0] rate_act_ff;
	logic [11:0] tick_ff;
	logic [7:0] slot_ff;
	logic on_ff, slot_end, period_end;

	assign slot_end = tick_ff >= sgp_pkg::slot_cycles(rate_act_ff) - 12'h001;
	assign period_end = slot_end && slot_ff == sgp_pkg::SLOT_LAST;

	always_ff @(posedge clock) begin
		if (rst) begin
			tick_ff <= 12'h000;
			slot_ff <= 8'h00;
		end else if (slot_end) begin
			tick_ff <= 12'h000;
			slot_ff <= period_end ? 8'h00 : slot_ff + 8'h01;
		end else begin
			tick_ff <= tick_ff + 12'h001;
		end
	end

	// new settings wait for the running period to finish
	always_ff @(posedge clock) begin
		if (rst) begin
			duty_act_ff <= sgp_pkg::DUTY_POR;
			rate_act_ff <= sgp_pkg::RATE_POR;
		end else if (period_end) begin
			duty_act_ff <= duty_value;
			rate_act_ff <= rate_code;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			on_ff <= 1'b0;
		end else begin
			on_ff <= (duty_act_ff == sgp_pkg::DUTY_FULL) ||
				(slot_ff < duty_act_ff);
		end
	end

	assign pwm_on = on_ff;

	default clocking @(posedge clock); endclocking
	default disable iff (rst);

	chk_duty_mid_period: assert property (
		!period_end |=> $stable(duty_act_ff) && $stable(rate_act_ff))
		else $error("pwm setting changed inside a period");
	chk_duty_full_on: assert property (
		duty_act_ff == sgp_pkg::DUTY_FULL [*2] |-> on_ff)
		else $error("full duty not on");
	chk_duty_zero_off: assert property (
		duty_act_ff == sgp_pkg::DUTY_OFF |=> !on_ff)
		else $error("zero duty not off");
endmodule // sgp_pwm_gen

// ### src/sgp_config_regs.sv
// pin function, pwm, thermal / current limit and host retention registers
`timescale 1ns/1ns
module sgp_config_regs (
	input wire logic clock, // system clock, 100 MHz
	input wire logic rst, // power-on reset, synchronous, active high
	input wire logic chip_select_n, // link select, active low
	input wire logic spi_clk, // link clock
	input wire logic spi_mosi, // link data in
	output logic spi_miso, // link data out
	output logic spi_miso_oe, // link data out drive enable
	input wire logic restart, // restart pulse from mode control
	input wire logic soft_reset, // soft reset pulse from mode control
	input wire logic normal_mode, // device in normal mode
	input wire logic fail_safe_mode, // device in fail-safe mode
	input wire logic cfg_lock0, // level-0 lock bit of the neighbour reg
	input wire logic cfg_lock1_bit, // level-1 lock bit as written
	input wire logic gpio_pin_in, // raw level of the pin
	output logic [2:0] pin_function, // active pin function code
	output logic fail_output_sel, // pin works as fail output
	output logic cyclic_hs_en, // high-side under cyclic sense timer
	output logic pin_off, // pin switched off
	output logic wake_input_en, // pin works as wake input
	output logic wake_default_src, // wake source while in fail-safe
	output logic wake_event, // filtered wake edge, one cycle
	output logic pwm_ls_on, // low-side switch on
	output logic pwm_hs_on, // high-side switch on
	output logic shutdown_threshold_sel, // 1 selects higher threshold
	output logic [1:0] main_supply_limit_adjust, // current limit step
	output logic lock1_active // level-1 lock engaged
);
	logic [2:0] func_ff, therm_ff;
	logic [7:0] duty_ff, ret_lo_ff, ret_hi_ff, rd_data;
	logic [1:0] rate_ff;
	logic lock1_ff;
	logic [6:0] rd_addr, wr_addr;
	logic [7:0] wr_data;
	logic wr_pulse, cs_rise, pwm_on;
	logic fo_ff, cyc_ff, off_ff, wake_en_ff, wake_src_ff;
	logic ls_ff, hs_ff, thr_ff;
	logic [1:0] lim_ff;
	logic [1:0] pin_sy_ff;
	logic pin_stable_ff, wake_evt_ff;
	logic [11:0] filt_ff;

	function automatic logic wr_hit(input logic [6:0] a);
		return wr_pulse && wr_addr == a;
	endfunction

	sgp_spi_port u_spi (
		.clock(clock),
		.rst(rst),
		.chip_select_n(chip_select_n),
		.spi_clk(spi_clk),
		.spi_mosi(spi_mosi),
		.rd_data(rd_data),
		.rd_addr(rd_addr),
		.wr_pulse(wr_pulse),
		.wr_addr(wr_addr),
		.wr_data(wr_data),
		.cs_rise(cs_rise),
		.spi_miso(spi_miso),
		.spi_miso_oe(spi_miso_oe)
	);

	sgp_pwm_gen u_pwm (
		.clock(clock),
		.rst(rst),
		.duty_value(duty_ff),
		.rate_code(rate_ff),
		.pwm_on(pwm_on)
	);

	// read mux; unmapped addresses read zero
	always_comb begin
		if (rd_addr == sgp_pkg::ADDR_PIN_FUNC) begin
			rd_data = {5'h00, func_ff};
		end else if (rd_addr == sgp_pkg::ADDR_DUTY) begin
			rd_data = duty_ff;
		end else if (rd_addr == sgp_pkg::ADDR_RATE) begin
			rd_data = {6'h00, rate_ff};
		end else if (rd_addr == sgp_pkg::ADDR_THERM) begin
			rd_data = {5'h00, therm_ff};
		end else if (rd_addr == sgp_pkg::ADDR_RET_LO) begin
			rd_data = ret_lo_ff;
		end else if (rd_addr == sgp_pkg::ADDR_RET_HI) begin
			rd_data = ret_hi_ff;
		end else begin
			rd_data = 8'h00;
		end
	end

	// restart keeps the function in force, which is its restart value
	always_ff @(posedge clock) begin
		if (rst) begin
			func_ff <= sgp_pkg::FUNC_POR;
		end else if (soft_reset) begin
			if (!cfg_lock0) begin
				func_ff <= sgp_pkg::FUNC_POR;
			end
		end else if (restart) begin
			func_ff <= func_ff;
		end else if (wr_hit(sgp_pkg::ADDR_PIN_FUNC) && !cfg_lock0) begin
			func_ff <= wr_data[sgp_pkg::FUNC_MSB:0];
		end
	end

	always_ff @(posedge clock) begin
		if (rst || soft_reset) begin
			duty_ff <= sgp_pkg::DUTY_POR;
		end else if (wr_hit(sgp_pkg::ADDR_DUTY)) begin
			duty_ff <= wr_data;
		end
	end

	always_ff @(posedge clock) begin
		if (rst || soft_reset) begin
			rate_ff <= sgp_pkg::RATE_POR;
		end else if (restart) begin
			rate_ff <= {1'b0, rate_ff[0]};
		end else if (wr_hit(sgp_pkg::ADDR_RATE)) begin
			rate_ff <= wr_data[sgp_pkg::RATE_MSB:0];
		end
	end

	// engages on the first select rise seen while cfg_lock1_bit is already high, whichever frame it ends
	always_ff @(posedge clock) begin
		if (rst) begin
			lock1_ff <= 1'b0;
		end else if (cs_rise && cfg_lock1_bit) begin
			lock1_ff <= 1'b1;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			therm_ff <= sgp_pkg::THERM_POR;
		end else if (soft_reset) begin
			if (!lock1_ff) begin
				therm_ff <= sgp_pkg::THERM_POR;
			end
		end else if (wr_hit(sgp_pkg::ADDR_THERM) && !lock1_ff && !restart) begin
			therm_ff <= wr_data[sgp_pkg::THR_BIT:0];
		end
	end

	// host-only storage, untouched by soft reset, restart or fail-safe
	always_ff @(posedge clock) begin
		if (rst) begin
			ret_lo_ff <= sgp_pkg::RET_POR;
			ret_hi_ff <= sgp_pkg::RET_POR;
		end else if (normal_mode) begin
			if (wr_hit(sgp_pkg::ADDR_RET_LO)) begin
				ret_lo_ff <= wr_data;
			end
			if (wr_hit(sgp_pkg::ADDR_RET_HI)) begin
				ret_hi_ff <= wr_data;
			end
		end
	end

	// function decode, registered so every output is a flip-flop
	always_ff @(posedge clock) begin
		if (rst) begin
			fo_ff <= 1'b1;
			cyc_ff <= 1'b0;
			off_ff <= 1'b0;
			wake_en_ff <= 1'b0;
			wake_src_ff <= 1'b0;
			ls_ff <= 1'b0;
			hs_ff <= 1'b0;
		end else begin
			fo_ff <= func_ff <= sgp_pkg::FUNC_FAIL_MAX;
			cyc_ff <= func_ff == sgp_pkg::FUNC_CYCLIC;
			off_ff <= func_ff == sgp_pkg::FUNC_OFF;
			wake_en_ff <= func_ff == sgp_pkg::FUNC_WAKE;
			wake_src_ff <= func_ff == sgp_pkg::FUNC_WAKE
				&& fail_safe_mode;
			ls_ff <= func_ff == sgp_pkg::FUNC_PWM_LS && pwm_on;
			hs_ff <= func_ff == sgp_pkg::FUNC_PWM_HS && pwm_on;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			thr_ff <= 1'b0;
			lim_ff <= 2'h1;
		end else begin
			thr_ff <= therm_ff[sgp_pkg::THR_BIT];
			lim_ff <= therm_ff[sgp_pkg::LIM_MSB:0];
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			pin_sy_ff <= 2'h0;
		end else begin
			pin_sy_ff <= {pin_sy_ff[0], gpio_pin_in};
		end
	end

	// static filter: a new level counts only after holding the full time
	always_ff @(posedge clock) begin
		if (rst) begin
			filt_ff <= 12'h000;
			pin_stable_ff <= 1'b0;
			wake_evt_ff <= 1'b0;
		end else if (pin_sy_ff[1] == pin_stable_ff) begin
			filt_ff <= 12'h000;
			wake_evt_ff <= 1'b0;
		end else if (filt_ff == 12'(sgp_pkg::WAKE_FILTER_CYC - 1)) begin
			filt_ff <= 12'h000;
			pin_stable_ff <= pin_sy_ff[1];
			wake_evt_ff <= wake_en_ff;
		end else begin
			filt_ff <= filt_ff + 12'h001;
			wake_evt_ff <= 1'b0;
		end
	end

	assign pin_function = func_ff;
	assign fail_output_sel = fo_ff;
	assign cyclic_hs_en = cyc_ff;
	assign pin_off = off_ff;
	assign wake_input_en = wake_en_ff;
	assign wake_default_src = wake_src_ff;
	assign wake_event = wake_evt_ff;
	assign pwm_ls_on = ls_ff;
	assign pwm_hs_on = hs_ff;
	assign shutdown_threshold_sel = thr_ff;
	assign main_supply_limit_adjust = lim_ff;
	assign lock1_active = lock1_ff;

	default clocking @(posedge clock); endclocking
	default disable iff (rst);

	sequence s_func_held(logic [2:0] code);
		func_ff == code [*2];
	endsequence

	// write strobes spelled out: a function reading module nets would
	// see post-edge values here instead of sampled ones
	chk_func_lock_write: assert property (
		wr_pulse && wr_addr == sgp_pkg::ADDR_PIN_FUNC && cfg_lock0
		|=> $stable(func_ff))
		else $error("locked pin function was written");
	chk_soft_func_keep: assert property (
		soft_reset && cfg_lock0 |=> $stable(func_ff))
		else $error("locked function reset");
	chk_func_off_dec: assert property (
		s_func_held(sgp_pkg::FUNC_OFF) |-> off_ff && !fo_ff)
		else $error("off code not decoded");
	chk_func_wake_dec: assert property (
		s_func_held(sgp_pkg::FUNC_WAKE)
		|-> wake_en_ff && (wake_src_ff == $past(fail_safe_mode)))
		else $error("wake code not decoded");
	chk_duty_soft_clr: assert property (
		soft_reset |=> duty_ff == sgp_pkg::DUTY_POR)
		else $error("duty kept over soft reset");
	chk_duty_restart: assert property (
		restart && !soft_reset && !wr_pulse |=> $stable(duty_ff))
		else $error("duty lost over restart");
	chk_therm_locked: assert property (
		lock1_ff && (soft_reset || (wr_pulse
		&& wr_addr == sgp_pkg::ADDR_THERM)) |=> $stable(therm_ff))
		else $error("locked limit settings changed");
	chk_lock1_sticky: assert property (
		lock1_ff |=> lock1_ff)
		else $error("level-1 lock released");
	chk_lock1_engage: assert property (
		cs_rise && cfg_lock1_bit |=> lock1_ff)
		else $error("lock did not engage");
	chk_ret_mode_gate: assert property (
		!normal_mode |=> $stable(ret_lo_ff) && $stable(ret_hi_ff))
		else $error("retention written outside normal");
	chk_reserved_zero: assert property (
		rd_addr != sgp_pkg::ADDR_DUTY && rd_addr[6:1] != 6'h0F
		|-> rd_data[7:3] == 5'h00)
		else $error("reserved bits not zero");
	chk_wake_filter: assert property (
		wake_evt_ff |-> $past(filt_ff) ==
		12'(sgp_pkg::WAKE_FILTER_CYC - 1))
		else $error("wake edge before filter time");
endmodule // sgp_config_regs

// ### verif/sgp_host_model.sv
// host-side serial master model that drives the link of the register set
`timescale 1ns/1ns
module sgp_host_model (
	output logic chip_select_n, // link select, active low
	output logic spi_clk, // link clock, still outside frames
	output logic spi_mosi, // command data
	input wire logic spi_miso, // reply data
	input wire logic spi_miso_oe // reply drive enable
);
	initial begin
		chip_select_n = 1'b1;
		spi_clk = 1'b0;
		spi_mosi = 1'b0;
	end

	// lsb first: address, write flag, data; fewer than 16 bits aborts
	task automatic xfer(input logic [6:0] a, input logic w,
		input logic [7:0] d, input int nbits, output logic [7:0] q);
		logic [15:0] f;
		f = {d, w, a};
		q = 8'h00;
		chip_select_n = 1'b0;
		#63;
		for (int i = 0; i < nbits; i++) begin
			spi_mosi = f[i];
			#62;
			spi_clk = 1'b1;
			// an undriven reply line must not pass for data
			if (i >= 8)
				q[i - 8] = spi_miso_oe ? spi_miso : 1'bx;
			#63;
			spi_clk = 1'b0;
		end
		#62;
		chip_select_n = 1'b1;
		// released data line shows no stale level
		spi_mosi = ~spi_mosi;
		#200;
	endtask
endmodule // sgp_host_model

// ### verif/tb_sgp_config_regs.sv
// self-checking bench of the pin, pwm, limit and retention registers
`timescale 1ns/1ns
module tb_sgp_config_regs;
	logic clock, rst, restart, soft_reset, normal_mode, fail_safe_mode;
	logic cfg_lock0, cfg_lock1_bit, gpio_pin_in;
	logic chip_select_n, spi_clk, spi_mosi, spi_miso, spi_miso_oe;
	logic [2:0] pin_function;
	logic fail_output_sel, cyclic_hs_en, pin_off, wake_input_en;
	logic wake_default_src, wake_event, pwm_ls_on, pwm_hs_on;
	logic shutdown_threshold_sel, lock1_active;
	logic [1:0] main_supply_limit_adjust;
	logic [7:0] q, v, lo, hi;
	int err_count, n_compared, seed, n;

	sgp_config_regs sgp_config_regs_inst (.clock(clock), .rst(rst),
		.chip_select_n(chip_select_n), .spi_clk(spi_clk),
		.spi_mosi(spi_mosi), .spi_miso(spi_miso),
		.spi_miso_oe(spi_miso_oe), .restart(restart),
		.soft_reset(soft_reset), .normal_mode(normal_mode),
		.fail_safe_mode(fail_safe_mode), .cfg_lock0(cfg_lock0),
		.cfg_lock1_bit(cfg_lock1_bit), .gpio_pin_in(gpio_pin_in),
		.pin_function(pin_function), .fail_output_sel(fail_output_sel),
		.cyclic_hs_en(cyclic_hs_en), .pin_off(pin_off),
		.wake_input_en(wake_input_en), .wake_default_src(wake_default_src),
		.wake_event(wake_event), .pwm_ls_on(pwm_ls_on),
		.pwm_hs_on(pwm_hs_on), .shutdown_threshold_sel(shutdown_threshold_sel),
		.main_supply_limit_adjust(main_supply_limit_adjust),
		.lock1_active(lock1_active));

	sgp_host_model sgp_host_model_inst (.chip_select_n(chip_select_n),
		.spi_clk(spi_clk), .spi_mosi(spi_mosi), .spi_miso(spi_miso),
		.spi_miso_oe(spi_miso_oe));

	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	task automatic check(input logic [7:0] seen, input logic [7:0] exp,
		input string what);
		n_compared++;
		if (seen !== exp) begin
			err_count++;
			$display("[ERR] %0t %s: seen %h expected %h", $time, what, seen,
				exp);
		end
	endtask

	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		@(posedge clock);
		#1;
		sgp_host_model_inst.xfer(a, 1'b1, d, 16, q);
	endtask

	task automatic rc(input logic [6:0] a, input logic [7:0] e,
		input string what);
		@(posedge clock);
		#1;
		sgp_host_model_inst.xfer(a, 1'b0, 8'h00, 16, q);
		check(q, e, what);
	endtask

	task automatic mode(input logic sr, input logic rs);
		@(posedge clock);
		#1;
		soft_reset = sr;
		restart = rs;
		@(posedge clock);
		#1;
		soft_reset = 1'b0;
		restart = 1'b0;
		repeat (3) @(posedge clock);
	endtask

	// expected pin decode: hs, ls, wake, off, cyclic, fail, wake source
	function automatic logic [7:0] dec(input logic [2:0] c, input logic fs);
		return {2'b00, c == 3'h5, c == 3'h4, c == 3'h3, c <= 3'h2,
			c == 3'h5 && fs, 1'b0};
	endfunction

	function automatic logic [7:0] pins();
		return {pwm_hs_on, pwm_ls_on, wake_input_en, pin_off, cyclic_hs_en,
			fail_output_sel, wake_default_src, 1'b0};
	endfunction

	task automatic end_of_test();
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// a full run needs about 18k cycles
	initial begin
		#900_000;
		err_count++;
		$display("[ERR] %0t watchdog expired", $time);
		end_of_test();
	end

	initial begin
		seed = 73716;
		err_count = 0;
		n_compared = 0;
		rst = 1'b1;
		normal_mode = 1'b1;
		{restart, soft_reset, fail_safe_mode} = 3'h0;
		{cfg_lock0, cfg_lock1_bit, gpio_pin_in} = 3'h0;
		repeat (3) @(posedge clock);
		#1;
		rst = 1'b0;
		rc(sgp_pkg::ADDR_PIN_FUNC, 8'h00, "pin por");
		rc(sgp_pkg::ADDR_DUTY, 8'h00, "duty por");
		rc(sgp_pkg::ADDR_RATE, 8'h00, "rate por");
		rc(sgp_pkg::ADDR_THERM, 8'h01, "therm por");
		rc(sgp_pkg::ADDR_RET_LO, 8'h00, "ret lo por");
		rc(sgp_pkg::ADDR_RET_HI, 8'h00, "ret hi por");
		rc(7'h20, 8'h00, "unmapped");
		$display("test por done");
		for (int c = 0; c < 8; c++) begin
			v = 8'($random(seed));
			v[2:0] = 3'(c);
			v[7] = v[7] | (c == 5);
			fail_safe_mode = v[7];
			wr(sgp_pkg::ADDR_PIN_FUNC, v);
			rc(sgp_pkg::ADDR_PIN_FUNC, {5'h00, v[2:0]}, "pin rd");
			check(pins(), dec(v[2:0], v[7]), "pin decode");
			check({5'h00, pin_function}, {5'h00, v[2:0]}, "pin out");
		end
		wr(sgp_pkg::ADDR_PIN_FUNC, 8'h05);
		fail_safe_mode = 1'b0;
		// a short glitch first, then a lasting level change
		for (int k = 0; k < 2; k++) begin
			@(posedge clock);
			#1;
			gpio_pin_in = ~gpio_pin_in;
			v = 8'h00;
			// look just after each edge so the one-cycle pulse is settled
			for (int t = 0; t < 2000; t++) begin
				@(posedge clock);
				#1;
				if (wake_event === 1'b1) begin
					v++;
					n = t;
				end
				if (k == 0 && t == 800)
					gpio_pin_in = ~gpio_pin_in;
			end
			check(v, 8'(k), "wake events");
		end
		check({7'h00, n >= sgp_pkg::WAKE_FILTER_CYC - 1 &&
			n <= sgp_pkg::WAKE_FILTER_CYC + 8}, 8'h01, "wake delay");
		$display("test pin function done");
		cfg_lock0 = 1'b1;
		wr(sgp_pkg::ADDR_PIN_FUNC, 8'h02);
		rc(sgp_pkg::ADDR_PIN_FUNC, 8'h05, "lock0 write");
		mode(1'b1, 1'b0);
		rc(sgp_pkg::ADDR_PIN_FUNC, 8'h05, "lock0 soft");
		cfg_lock0 = 1'b0;
		mode(1'b0, 1'b1);
		rc(sgp_pkg::ADDR_PIN_FUNC, 8'h05, "pin restart");
		mode(1'b1, 1'b0);
		rc(sgp_pkg::ADDR_PIN_FUNC, 8'h00, "pin soft");
		$display("test lock0 done");
		// duty far above the slot reached so far, so an early take shows
		v = 8'($random(seed)) | 8'h80;
		wr(sgp_pkg::ADDR_DUTY, v);
		wr(sgp_pkg::ADDR_RATE, 8'hFF);
		rc(sgp_pkg::ADDR_RATE, 8'h03, "rate rd");
		wr(sgp_pkg::ADDR_PIN_FUNC, 8'h06);
		repeat (100) @(posedge clock);
		#1;
		// the period running since reset still uses duty zero
		check({6'h00, pwm_hs_on, pwm_ls_on}, 8'h00, "pwm hold");
		mode(1'b0, 1'b1);
		rc(sgp_pkg::ADDR_DUTY, v, "duty restart");
		rc(sgp_pkg::ADDR_RATE, 8'h01, "rate restart");
		wr(sgp_pkg::ADDR_RATE, 8'hFA);
		rc(sgp_pkg::ADDR_RATE, 8'h02, "rate code two");
		mode(1'b1, 1'b0);
		rc(sgp_pkg::ADDR_DUTY, 8'h00, "duty soft");
		rc(sgp_pkg::ADDR_RATE, 8'h00, "rate soft");
		$display("test pwm done");
		for (int i = 0; i < 4; i++) begin
			v = 8'($random(seed));
			wr(sgp_pkg::ADDR_THERM, v);
			rc(sgp_pkg::ADDR_THERM, {5'h00, v[2:0]}, "therm rd");
			check({5'h00, shutdown_threshold_sel, main_supply_limit_adjust},
				{5'h00, v[2:0]}, "therm out");
		end
		mode(1'b1, 1'b0);
		rc(sgp_pkg::ADDR_THERM, 8'h01, "therm soft");
		wr(sgp_pkg::ADDR_THERM, {5'h00, v[2:0]});
		cfg_lock1_bit = 1'b1;
		repeat (20) @(posedge clock);
		#1;
		check({7'h00, lock1_active}, 8'h00, "lock1 early");
		rc(sgp_pkg::ADDR_THERM, {5'h00, v[2:0]}, "therm pre lock");
		check({7'h00, lock1_active}, 8'h01, "lock1 on");
		cfg_lock1_bit = 1'b0;
		wr(sgp_pkg::ADDR_THERM, {5'h00, ~v[2:0]});
		mode(1'b1, 1'b0);
		rc(sgp_pkg::ADDR_THERM, {5'h00, v[2:0]}, "therm locked");
		check({7'h00, lock1_active}, 8'h01, "lock1 kept");
		$display("test therm done");
		lo = 8'($random(seed));
		hi = 8'($random(seed));
		normal_mode = 1'b0;
		wr(sgp_pkg::ADDR_RET_LO, lo);
		rc(sgp_pkg::ADDR_RET_LO, 8'h00, "ret stop write");
		normal_mode = 1'b1;
		wr(sgp_pkg::ADDR_RET_LO, lo);
		wr(sgp_pkg::ADDR_RET_HI, hi);
		fail_safe_mode = 1'b1;
		mode(1'b0, 1'b1);
		mode(1'b1, 1'b0);
		#1;
		sgp_host_model_inst.xfer(sgp_pkg::ADDR_RET_LO, 1'b1, ~lo, 12, q);
		normal_mode = 1'b0;
		rc(sgp_pkg::ADDR_RET_LO, lo, "ret lo kept");
		rc(sgp_pkg::ADDR_RET_HI, hi, "ret hi kept");
		$display("test retention done");
		end_of_test();
	end
endmodule // tb_sgp_config_regs
